// [rtl/wosopt_bank.sv]
// Write-once system option registers on an Avalon-MM slave port.
// Assumes synchronous inputs on I_REF_CLK and a separate power-on flag that
// tells a power-on reset from other resets while I_RST_N is low and at the
// first I_REF_CLK edge after its release.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/10ps

// The header is pulled in here as well, so this file does not depend on
// the package having been compiled in the same unit to see the macros.
`include "wosopt_regs.svh"

module wosopt_bank
	import wosopt_pkg::*;
(
	input  wire logic                      I_REF_CLK,
	input  wire logic                      I_RST_N,
	input  wire logic                      I_POR_FLAG,
	input  wire logic                      I_STOP_MODE,
	input  wire logic                      I_LVR_WAKE,
	input  wire logic [`WOSOPT_ADDR_W-1:0] I_AVS_ADDRESS,
	input  wire logic                      I_AVS_READ,
	input  wire logic                      I_AVS_WRITE,
	input  wire logic [7:0]                I_AVS_WRITEDATA,
	output logic [7:0]                     O_AVS_READDATA,
	output logic                           O_AVS_WAITREQUEST,
	output wosopt_ctrl_type                O_CTRL,
	output logic                           O_ILLEGAL_STOP,
	output logic                           O_LV_MONITOR_ON,
	output logic                           O_LV_RESET_ALLOW,
	output wosopt_period_type              O_PERIODS
);

	// Bus handshake states: every access takes one wait cycle.
	typedef enum logic [1:0]
	{
		WOSOPT_IDLE,
		WOSOPT_ACK,
		WOSOPT_DONE
	} wosopt_bus_type;

	wosopt_bus_type bus_state_reg;
	wosopt_bus_type bus_state_next;
	logic [7:0]     high_reg;
	logic [7:0]     low_reg;
	logic           high_locked_reg;
	logic           low_locked_reg;
	logic           por_seen_reg;
	logic           rst_pin_keep_reg;
	logic           trip_keep_reg;
	logic           stop_cmd;
	logic           hit_high;
	logic           hit_low;
	logic           wr_go;
	logic [7:0]     rd_value;

	// Decodes one of the two option addresses; used for reads and writes.
	function automatic logic addr_is
	(
		input logic [`WOSOPT_ADDR_W-1:0] addr,
		input logic [`WOSOPT_ADDR_W-1:0] ofs
	);
		addr_is = (addr == ofs);
	endfunction : addr_is

	assign hit_high = addr_is(I_AVS_ADDRESS, `WOSOPT_OFS_HIGH);
	assign hit_low  = addr_is(I_AVS_ADDRESS, `WOSOPT_OFS_LOW);
	assign stop_cmd = I_AVS_READ | I_AVS_WRITE;

	// The request is answered on the second edge it is held.
	always_comb
	begin
		bus_state_next = bus_state_reg;
		case (bus_state_reg)
			WOSOPT_IDLE:
				if (stop_cmd)
					bus_state_next = WOSOPT_ACK;
			WOSOPT_ACK:
				bus_state_next = WOSOPT_DONE;
			WOSOPT_DONE:
				bus_state_next = WOSOPT_IDLE;
			default:
				bus_state_next = WOSOPT_IDLE;
		endcase
	end

	// Waitrequest drops only in the acknowledge cycle.
	assign O_AVS_WAITREQUEST = !(bus_state_reg == WOSOPT_ACK);
	assign wr_go = (bus_state_reg == WOSOPT_ACK) && I_AVS_WRITE;

	// Handshake state register.
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			bus_state_reg <= WOSOPT_IDLE;
		else
			bus_state_reg <= bus_state_next;
	end

	// Read data is registered one cycle ahead so it stands at the ack edge.
	always_comb
	begin
		rd_value = 8'h00;
		if (hit_high)
			rd_value = high_reg;
		else if (hit_low)
			rd_value = low_reg;
	end

	// Unmapped addresses read as zero and writes to them are dropped.
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			O_AVS_READDATA <= 8'h00;
		else if (bus_state_reg == WOSOPT_IDLE && I_AVS_READ)
			O_AVS_READDATA <= rd_value;
	end

	// Power-on marking is taken by a clocked process after the release,
	// because an asynchronous reset may only load constants.
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			por_seen_reg <= 1'h0;
		else
			por_seen_reg <= 1'h1;
	end

	// Shadow copies of the reset-surviving bits; they never see the async
	// reset, so a warm reset leaves them intact.
	always_ff @(posedge I_REF_CLK)
	begin
		if (!por_seen_reg && I_POR_FLAG)
		begin
			rst_pin_keep_reg <= `WOSOPT_BIT_CLEAR;
			trip_keep_reg    <= `WOSOPT_BIT_CLEAR;
		end
		else if (wr_go && hit_low && !low_locked_reg)
			rst_pin_keep_reg <= I_AVS_WRITEDATA[`WOSOPT_LO_RST_PIN_ON];
		else if (wr_go && hit_high && !high_locked_reg)
			trip_keep_reg <= I_AVS_WRITEDATA[`WOSOPT_HI_LV_TRIP];
	end

	// Lock flags: the first write to each register closes it.
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			high_locked_reg <= 1'h0;
			low_locked_reg  <= 1'h0;
		end
		else if (wr_go)
		begin
			if (hit_high)
				high_locked_reg <= 1'h1;
			if (hit_low)
				low_locked_reg  <= 1'h1;
		end
	end

	// Upper register: all bits clear on reset except trip mode, which is
	// refreshed from its shadow once the reset kind is known.
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			high_reg <= `WOSOPT_HIGH_RESET;
		else if (!por_seen_reg)
			high_reg[`WOSOPT_HI_LV_TRIP] <= I_POR_FLAG ?
				`WOSOPT_BIT_CLEAR : trip_keep_reg;
		else if (wr_go && hit_high && !high_locked_reg)
			high_reg <= I_AVS_WRITEDATA;
	end

	// Lower register: reset-pin bit survives warm resets via its shadow.
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			low_reg <= `WOSOPT_LOW_RESET;
		else if (!por_seen_reg)
			low_reg[`WOSOPT_LO_RST_PIN_ON] <= I_POR_FLAG ?
				`WOSOPT_BIT_CLEAR : rst_pin_keep_reg;
		else if (wr_go && hit_low && !low_locked_reg)
			low_reg <= I_AVS_WRITEDATA & `WOSOPT_LOW_MASK;
	end

	// Field fan-out; bits above the lower layout read as zero.
	always_comb
	begin
		O_CTRL.int_pin_pullup_off    = low_reg[`WOSOPT_LO_PULLUP_OFF];
		O_CTRL.int_pin_function_on   = low_reg[`WOSOPT_LO_INT_ON];
		O_CTRL.osc_source            = wosopt_osc_type'(
			{low_reg[`WOSOPT_LO_OSC_HI], low_reg[`WOSOPT_LO_OSC_LO]});
		O_CTRL.reset_pin_function_on = low_reg[`WOSOPT_LO_RST_PIN_ON];
		O_CTRL.timeout_rate_select   = high_reg[`WOSOPT_HI_RATE];
		O_CTRL.lowvolt_stop_enable   = high_reg[`WOSOPT_HI_LV_STOP];
		O_CTRL.lowvolt_reset_disable = high_reg[`WOSOPT_HI_LV_RSTD];
		O_CTRL.lowvolt_power_disable = high_reg[`WOSOPT_HI_LV_PWRD];
		O_CTRL.lowvolt_trip_mode     = high_reg[`WOSOPT_HI_LV_TRIP];
		O_CTRL.short_recovery        = high_reg[`WOSOPT_HI_SHORT_REC];
		O_CTRL.stop_enable           = high_reg[`WOSOPT_HI_STOP_EN];
		O_CTRL.watchdog_disable      = high_reg[`WOSOPT_HI_WD_DIS];
	end

	// A stop opcode is illegal while the stop enable is clear.
	assign O_ILLEGAL_STOP = !high_reg[`WOSOPT_HI_STOP_EN];

	// The monitor runs when powered, and in stop only if stop-enabled.
	assign O_LV_MONITOR_ON = !high_reg[`WOSOPT_HI_LV_PWRD] &&
		(!I_STOP_MODE || high_reg[`WOSOPT_HI_LV_STOP]);
	assign O_LV_RESET_ALLOW = O_LV_MONITOR_ON &&
		!high_reg[`WOSOPT_HI_LV_RSTD];

	// Periods are registered so downstream timers see stable values.
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			O_PERIODS.watchdog_period <= `WOSOPT_WD_LONG;
			O_PERIODS.wakeup_period   <= `WOSOPT_WAKE_LONG;
			O_PERIODS.recovery_delay  <= `WOSOPT_REC_LONG;
		end
		else
		begin
			O_PERIODS.watchdog_period <= high_reg[`WOSOPT_HI_RATE] ?
				`WOSOPT_WD_SHORT : `WOSOPT_WD_LONG;
			O_PERIODS.wakeup_period <= high_reg[`WOSOPT_HI_RATE] ?
				`WOSOPT_WAKE_SHORT : `WOSOPT_WAKE_LONG;
			// A low-voltage wake never takes the short path, since the
			// monitor may not have settled in 32 cycles.
			O_PERIODS.recovery_delay <=
				(high_reg[`WOSOPT_HI_SHORT_REC] && !I_LVR_WAKE) ?
				`WOSOPT_REC_SHORT : `WOSOPT_REC_LONG;
		end
	end

endmodule : wosopt_bank

// [rtl/wosopt_pkg.sv]
// Types shared by the write-once option bank.
// Assumes the register header sits on the include path.
package wosopt_pkg;
	`include "wosopt_regs.svh"

	// Clock source encodings.
	typedef enum logic [1:0]
	{
		WOSOPT_OSC_INTERNAL = 2'h0,
		WOSOPT_OSC_EXTERNAL = 2'h1,
		WOSOPT_OSC_RC       = 2'h2,
		WOSOPT_OSC_CRYSTAL  = 2'h3
	} wosopt_osc_type;

	// Static controls fanned out to the rest of the chip.
	typedef struct packed
	{
		logic           int_pin_pullup_off;
		logic           int_pin_function_on;
		wosopt_osc_type osc_source;
		logic           reset_pin_function_on;
		logic           timeout_rate_select;
		logic           lowvolt_stop_enable;
		logic           lowvolt_reset_disable;
		logic           lowvolt_power_disable;
		logic           lowvolt_trip_mode;
		logic           short_recovery;
		logic           stop_enable;
		logic           watchdog_disable;
	} wosopt_ctrl_type;

	// Derived periods, in cycles of the relevant oscillator.
	typedef struct packed
	{
		logic [31:0] watchdog_period;
		logic [31:0] wakeup_period;
		logic [31:0] recovery_delay;
	} wosopt_period_type;
endpackage : wosopt_pkg

// [rtl/wosopt_regs.svh]
// Register offsets, field positions and timing figures of the option bank.
// Assumes inclusion by its bare name from the option package and module.
`ifndef WOSOPT_REGS_SVH
`define WOSOPT_REGS_SVH

// Byte offsets of the two option registers (printed offsets kept as given).
`define WOSOPT_OFS_LOW          16'h001E
`define WOSOPT_OFS_HIGH         16'h001F
`define WOSOPT_ADDR_W           16

// Upper option register field positions.
`define WOSOPT_HI_RATE          7
`define WOSOPT_HI_LV_STOP       6
`define WOSOPT_HI_LV_RSTD       5
`define WOSOPT_HI_LV_PWRD       4
`define WOSOPT_HI_LV_TRIP       3
`define WOSOPT_HI_SHORT_REC     2
`define WOSOPT_HI_STOP_EN       1
`define WOSOPT_HI_WD_DIS        0

// Lower option register field positions.
`define WOSOPT_LO_PULLUP_OFF    0
`define WOSOPT_LO_INT_ON        1
`define WOSOPT_LO_OSC_LO        2
`define WOSOPT_LO_OSC_HI        3
`define WOSOPT_LO_RST_PIN_ON    4

// Reset values.
`define WOSOPT_HIGH_RESET       8'h00
`define WOSOPT_LOW_RESET        8'h00
`define WOSOPT_BIT_CLEAR        1'h0

// Writable bits of the lower register; the bits above its layout read zero.
`define WOSOPT_LOW_MASK         8'h1F

// Period figures, in oscillator or wakeup-oscillator cycles.
`define WOSOPT_WD_SHORT         32'h00001FF0
`define WOSOPT_WD_LONG          32'h0003FFF0
`define WOSOPT_WAKE_SHORT       32'h00000200
`define WOSOPT_WAKE_LONG        32'h00004000
`define WOSOPT_REC_SHORT        32'h00000020
`define WOSOPT_REC_LONG         32'h00001000

`endif

// [tb/tb.sv]
// Self-checking bench for the option bank over its Avalon-MM port.
// Assumes the package, header and checker are compiled before this file.
`timescale 1ns/10ps
`include "wosopt_regs.svh"
module tb
	import wosopt_pkg::*;
;
	logic              ref_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              por_flag = 1'b1;
	logic              stop_mode = 1'b0;
	logic              lvr_wake = 1'b0;
	logic [15:0]       avs_addr = 16'h0000;
	logic              avs_rd = 1'b0;
	logic              avs_wr = 1'b0;
	logic [7:0]        avs_wdata = 8'h00;
	logic [7:0]        avs_rdata;
	logic              avs_wait;
	wosopt_ctrl_type   ctrl;
	logic              ill_stop;
	logic              mon_on;
	logic              rst_allow;
	wosopt_period_type periods;
	int                n_errors = 0;
	int                n_checks = 0;
	logic [7:0]        hi_tab [4] = '{8'hAC, 8'h53, 8'hC9, 8'h36};
	logic [7:0]        lo_tab [4] = '{8'hF0, 8'h06, 8'h19, 8'hEF};
	logic [7:0]        q;
	logic [7:0]        h;
	logic              mon;

	// Free-running 50 MHz reference clock.
	always #10 ref_clk = ~ref_clk;

	wosopt_bank wosopt_bank_i
	(
		.I_REF_CLK(ref_clk), .I_RST_N(rst_n), .I_POR_FLAG(por_flag),
		.I_STOP_MODE(stop_mode), .I_LVR_WAKE(lvr_wake),
		.I_AVS_ADDRESS(avs_addr), .I_AVS_READ(avs_rd), .I_AVS_WRITE(avs_wr),
		.I_AVS_WRITEDATA(avs_wdata), .O_AVS_READDATA(avs_rdata),
		.O_AVS_WAITREQUEST(avs_wait), .O_CTRL(ctrl),
		.O_ILLEGAL_STOP(ill_stop), .O_LV_MONITOR_ON(mon_on),
		.O_LV_RESET_ALLOW(rst_allow), .O_PERIODS(periods)
	);

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask : chk

	// One bus access; the request stands until waitrequest is seen low at a
	// rising edge, and read data is taken at that same edge. Only the
	// watchdog ends a wait that never gets an answer.
	task automatic bus(input logic wr, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] rq);
		int   n;
		logic wq;
		n = 0;
		wq = 1'b1;
		@(posedge ref_clk);
		avs_addr <= a;
		avs_wdata <= d;
		avs_rd <= !wr;
		avs_wr <= wr;
		while (wq)
		begin
			@(posedge ref_clk);
			wq = avs_wait;
			n++;
		end
		rq = avs_rdata;
		avs_rd <= 1'b0;
		avs_wr <= 1'b0;
		chk(n, 32'h2);
	endtask : bus

	// The power-on flag stays put past release, where the bank samples it.
	task do_reset(input logic por);
		@(posedge ref_clk);
		por_flag <= por;
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask : do_reset

	task final_report;
		$display("Checks %0d, mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	// Cuts a hang short well past the roughly 150 cycles the tests need.
	initial
	begin
		#200000;
		n_errors++;
		final_report();
	end

	// Power-on first, then warm resets that must keep two sticky bits.
	initial
	begin
		for (int k = 0; k < 4; k++)
		begin
			do_reset(k == 0);
			h = hi_tab[k];
			bus(1'b0, `WOSOPT_OFS_HIGH, 8'h00, q);
			chk(q, (k == 0) ? 8'h00 : hi_tab[k-1] & 8'h08);
			bus(1'b0, `WOSOPT_OFS_LOW, 8'h00, q);
			chk(q, (k == 0) ? 8'h00 : lo_tab[k-1] & 8'h10);
			bus(1'b1, `WOSOPT_OFS_HIGH, h, q);
			bus(1'b1, `WOSOPT_OFS_LOW, lo_tab[k], q);
			bus(1'b1, `WOSOPT_OFS_HIGH, ~h, q);
			bus(1'b1, `WOSOPT_OFS_LOW, ~lo_tab[k], q);
			bus(1'b1, 16'h0020, 8'hFF, q);
			bus(1'b0, 16'h0020, 8'h00, q);
			chk(q, 8'h00);
			bus(1'b0, `WOSOPT_OFS_HIGH, 8'h00, q);
			chk(q, h);
			bus(1'b0, `WOSOPT_OFS_LOW, 8'h00, q);
			chk(q, lo_tab[k] & 8'h1F);
			chk(ctrl[7:0], h);
			chk(ctrl.osc_source, lo_tab[k][3:2]);
			chk({ctrl.int_pin_pullup_off, ctrl.int_pin_function_on,
				ctrl.reset_pin_function_on},
				{lo_tab[k][0], lo_tab[k][1], lo_tab[k][4]});
			stop_mode <= ~k[0];
			lvr_wake <= k[1];
			repeat (2) @(posedge ref_clk);
			@(negedge ref_clk);
			mon = !h[4] && (!stop_mode || h[6]);
			chk(periods.watchdog_period,
				h[7] ? `WOSOPT_WD_SHORT : `WOSOPT_WD_LONG);
			chk(periods.wakeup_period,
				h[7] ? `WOSOPT_WAKE_SHORT : `WOSOPT_WAKE_LONG);
			chk(periods.recovery_delay, (h[2] && !lvr_wake) ?
				`WOSOPT_REC_SHORT : `WOSOPT_REC_LONG);
			chk({ill_stop, mon_on, rst_allow},
				{!h[1], mon, mon && !h[5]});
			$display("Test %0d done, mismatches so far %0d", k, n_errors);
		end
		final_report();
	end
endmodule : tb

// [tb/wosopt_bank_asserts.sv]
// Concurrent checks for the write-once option bank, bound to its top.
// Assumes the option package and register header are compiled first.
`timescale 1ns/10ps
`include "wosopt_regs.svh"
module wosopt_bank_chk
	import wosopt_pkg::*;
(
	input wire logic                      I_REF_CLK,
	input wire logic                      I_RST_N,
	input wire logic                      I_STOP_MODE,
	input wire logic                      I_LVR_WAKE,
	input wire logic [`WOSOPT_ADDR_W-1:0] I_AVS_ADDRESS,
	input wire logic                      I_AVS_READ,
	input wire logic                      I_AVS_WRITE,
	input wire logic                      O_AVS_WAITREQUEST,
	input wire wosopt_ctrl_type           O_CTRL,
	input wire logic                      O_ILLEGAL_STOP,
	input wire logic                      O_LV_MONITOR_ON,
	input wire logic                      O_LV_RESET_ALLOW,
	input wire wosopt_period_type         O_PERIODS
);
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RST_N);

	logic hi_lock_reg;
	logic lo_lock_reg;
	logic wr_ack;

	// A finished write spends its register until the next reset.
	assign wr_ack = I_AVS_WRITE && !O_AVS_WAITREQUEST;
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			hi_lock_reg <= 1'b0;
			lo_lock_reg <= 1'b0;
		end
		else
		begin
			if (wr_ack && I_AVS_ADDRESS == `WOSOPT_OFS_HIGH)
				hi_lock_reg <= 1'b1;
			if (wr_ack && I_AVS_ADDRESS == `WOSOPT_OFS_LOW)
				lo_lock_reg <= 1'b1;
		end
	end

	// A new request gets exactly one ready cycle on the following edge.
	sequence s_req;
		$rose(I_AVS_READ || I_AVS_WRITE);
	endsequence
	sequence s_ack;
		!O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
	endsequence

	AST_ANSWER:
		assert property (s_req |=> s_ack)
		else $error("Request not answered by one ready cycle.");
	AST_LOCK_HI:
		assert property (hi_lock_reg |=> $stable(O_CTRL[7:0]))
		else $error("Upper options changed after their write.");
	AST_LOCK_LO:
		assert property (lo_lock_reg |=> $stable(O_CTRL[12:8]))
		else $error("Lower options changed after their write.");
	AST_ILLEGAL:
		assert property (O_ILLEGAL_STOP == !O_CTRL.stop_enable)
		else $error("Illegal stop flag disagrees with enable bit.");
	AST_MONITOR:
		assert property (O_LV_MONITOR_ON == (!O_CTRL.lowvolt_power_disable
			&& (!I_STOP_MODE || O_CTRL.lowvolt_stop_enable)))
		else $error("Monitor power state is wrong.");
	AST_ALLOW:
		assert property (O_LV_RESET_ALLOW ==
			(O_LV_MONITOR_ON && !O_CTRL.lowvolt_reset_disable))
		else $error("Monitor reset permission is wrong.");
	AST_WD_PERIOD:
		assert property (O_PERIODS.watchdog_period ==
			($past(O_CTRL.timeout_rate_select) ?
			`WOSOPT_WD_SHORT : `WOSOPT_WD_LONG))
		else $error("Watchdog period does not follow rate bit.");
	AST_WAKE_PERIOD:
		assert property (O_PERIODS.wakeup_period ==
			($past(O_CTRL.timeout_rate_select) ?
			`WOSOPT_WAKE_SHORT : `WOSOPT_WAKE_LONG))
		else $error("Wakeup period does not follow rate bit.");
	AST_RECOVERY:
		assert property (O_PERIODS.recovery_delay ==
			(($past(I_LVR_WAKE) || !$past(O_CTRL.short_recovery)) ?
			`WOSOPT_REC_LONG : `WOSOPT_REC_SHORT))
		else $error("Stop recovery delay is wrong.");
endmodule : wosopt_bank_chk

bind wosopt_bank wosopt_bank_chk wosopt_bank_chk_i
(
	.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_STOP_MODE(I_STOP_MODE),
	.I_LVR_WAKE(I_LVR_WAKE), .I_AVS_ADDRESS(I_AVS_ADDRESS),
	.I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
	.O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_CTRL(O_CTRL),
	.O_ILLEGAL_STOP(O_ILLEGAL_STOP), .O_LV_MONITOR_ON(O_LV_MONITOR_ON),
	.O_LV_RESET_ALLOW(O_LV_RESET_ALLOW), .O_PERIODS(O_PERIODS)
);
